// File: logic/fsq_pkg.sv
/*
 * Constants for the flash status-pin and block-lock controller: command
 * codes, field positions, reset values and bus timing counts.
 * Assumes a 20 MHz controller clock and an asynchronous parallel flash bus.
 */
package fsq_pkg;
    localparam int unsigned CLK_PERIOD_NS   = 50;
    localparam int unsigned WR_PULSE_NS     = 100;
    localparam int unsigned RD_ACCESS_NS    = 150;
    localparam int unsigned WR_PULSE_CYC    =
        (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RD_ACCESS_CYC   =
        (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  WR_PULSE_CNT    = 4'(WR_PULSE_CYC);
    localparam logic [3:0]  RD_ACCESS_CNT   = 4'(RD_ACCESS_CYC);

    localparam int unsigned ADDR_W          = 24;
    localparam int unsigned DATA_W          = 16;

    localparam logic [15:0] CMD_PIN_SETUP   = 16'h00B8;
    localparam logic [15:0] CMD_LOCK_SETUP  = 16'h0060;
    localparam logic [15:0] CMD_LOCK_SET    = 16'h0001;
    localparam logic [15:0] CMD_LOCK_CLEAR  = 16'h00D0;
    localparam logic [15:0] CMD_READ_ARRAY  = 16'h00FF;
    localparam logic [15:0] CMD_READ_INFO   = 16'h0090;
    localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
    localparam logic [15:0] CMD_CLR_STATUS  = 16'h0050;

    localparam logic [7:0]  PIN_CFG_LEVEL   = 8'h00;
    localparam logic [7:0]  PIN_CFG_MASK    = 8'h03;
    localparam logic [23:0] LOCK_INFO_OFS   = 24'h000002;

    localparam int unsigned SR_READY_BIT    = 7;
    localparam int unsigned SR_ERASE_ERR    = 5;
    localparam int unsigned SR_PROG_ERR     = 4;
    localparam int unsigned LOCK_BIT        = 0;

    typedef enum logic [2:0] {
        FSQ_OP_PIN_CFG   = 3'h0,
        FSQ_OP_LOCK_SET  = 3'h1,
        FSQ_OP_LOCK_CLR  = 3'h2,
        FSQ_OP_LOCK_READ = 3'h3,
        FSQ_OP_CLR_STAT  = 3'h4,
        FSQ_OP_READ_ARR  = 3'h5
    } fsq_op_t;
endpackage

// File: logic/fsq_ctrl.sv
/*
 * Host-side controller that drives a parallel NOR flash over its command
 * bus: status-pin configuration, block lock set/clear, lock readback,
 * status clear and return to array reads.
 * Assumes the flash pins are asynchronous to mclk_i; the data bus is
 * two-way and resolved outside from the output enable.
 */
`timescale 1ns/10ps

module fsq_ctrl (
    input  wire logic                      mclk_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      req_i,
    input  wire fsq_pkg::fsq_op_t          op_i,
    input  wire logic [fsq_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [7:0]                cfg_i,
    output logic                           busy_o,
    output logic                           done_o,
    output logic                           err_o,
    output logic [fsq_pkg::DATA_W-1:0]     rdata_o,
    output logic                           locked_o,
    output logic                           pin_event_o,
    output logic [fsq_pkg::ADDR_W-1:0]     flash_addr_o,
    output logic [fsq_pkg::DATA_W-1:0]     flash_dq_o,
    output logic                           flash_dq_oe_o,
    input  wire logic [fsq_pkg::DATA_W-1:0] flash_dq_i,
    output logic                           flash_ce_n_o,
    output logic                           flash_we_n_o,
    output logic                           flash_oe_n_o,
    input  wire logic                      status_pin_i
);
    typedef enum logic [7:0] {
        S_IDLE  = 8'h01,
        S_POLL  = 8'h02,
        S_WR1   = 8'h04,
        S_WR2   = 8'h08,
        S_WAIT  = 8'h10,
        S_RDST  = 8'h20,
        S_RDINF = 8'h40,
        S_DONE  = 8'h80
    } fsq_state_t;

    fsq_state_t                      state;
    fsq_pkg::fsq_op_t                op;
    logic [fsq_pkg::ADDR_W-1:0]      addr;
    logic [7:0]                      cfg;
    logic [3:0]                      cnt;
    logic                            phase;
    logic                            rd_phase;
    logic [1:0]                      pin_sync;
    logic [fsq_pkg::DATA_W-1:0]      dq_meta;
    logic [fsq_pkg::DATA_W-1:0]      dq_sync;
    logic                            pin_prev;
    logic                            two_cycle;
    logic [fsq_pkg::DATA_W-1:0]      first_cmd;
    logic [fsq_pkg::DATA_W-1:0]      second_cmd;

    // Pin and data pass two flip-flops before any logic sees them
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_sync <= 2'h3;
            dq_meta  <= 16'h0000;
            dq_sync  <= 16'h0000;
            pin_prev <= 1'b1;
        end else begin
            pin_sync <= {pin_sync[0], status_pin_i};
            dq_meta  <= flash_dq_i;
            dq_sync  <= dq_meta;
            pin_prev <= pin_sync[1];
        end
    end

    // Low-going edge of the status pin: start of a busy period in level mode
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_event_o <= 1'b0;
        end else begin
            pin_event_o <= pin_prev & ~pin_sync[1];
        end
    end

    always_comb begin
        two_cycle  = 1'b1;
        first_cmd  = fsq_pkg::CMD_LOCK_SETUP;
        second_cmd = fsq_pkg::CMD_LOCK_SET;
        case (op)
            fsq_pkg::FSQ_OP_PIN_CFG: begin
                first_cmd  = fsq_pkg::CMD_PIN_SETUP;
                // Reserved bits sent as zero
                second_cmd = {8'h00, cfg & fsq_pkg::PIN_CFG_MASK};
            end
            fsq_pkg::FSQ_OP_LOCK_SET: begin
                second_cmd = fsq_pkg::CMD_LOCK_SET;
            end
            fsq_pkg::FSQ_OP_LOCK_CLR: begin
                second_cmd = fsq_pkg::CMD_LOCK_CLEAR;
            end
            fsq_pkg::FSQ_OP_LOCK_READ: begin
                first_cmd  = fsq_pkg::CMD_READ_INFO;
                second_cmd = fsq_pkg::CMD_READ_ARRAY;
            end
            fsq_pkg::FSQ_OP_CLR_STAT: begin
                two_cycle  = 1'b0;
                first_cmd  = fsq_pkg::CMD_CLR_STATUS;
            end
            fsq_pkg::FSQ_OP_READ_ARR: begin
                two_cycle  = 1'b0;
                first_cmd  = fsq_pkg::CMD_READ_ARRAY;
            end
            default: begin
                two_cycle  = 1'b0;
                first_cmd  = fsq_pkg::CMD_READ_ARRAY;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state         <= S_IDLE;
            op            <= fsq_pkg::FSQ_OP_READ_ARR;
            addr          <= 24'h000000;
            cfg           <= 8'h00;
            cnt           <= 4'h0;
            phase         <= 1'b0;
            rd_phase      <= 1'b0;
            busy_o        <= 1'b0;
            done_o        <= 1'b0;
            err_o         <= 1'b0;
            rdata_o       <= 16'h0000;
            locked_o      <= 1'b0;
            flash_addr_o  <= 24'h000000;
            flash_dq_o    <= 16'h0000;
            flash_dq_oe_o <= 1'b0;
            flash_ce_n_o  <= 1'b1;
            flash_we_n_o  <= 1'b1;
            flash_oe_n_o  <= 1'b1;
        end else begin
            done_o <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (req_i) begin
                        op       <= op_i;
                        addr     <= addr_i;
                        cfg      <= cfg_i;
                        busy_o   <= 1'b1;
                        phase    <= 1'b0;
                        // Reads may still return array data that looks
                        // ready, so select status reads first
                        rd_phase <= 1'b1;
                        cnt      <= fsq_pkg::WR_PULSE_CNT;
                        state    <= S_WR1;
                    end
                end
                // Read status first; issue only when ready
                S_POLL: begin
                    flash_ce_n_o <= 1'b0;
                    flash_oe_n_o <= 1'b0;
                    if (cnt != 4'h0) begin
                        cnt <= cnt - 4'h1;
                    end else begin
                        flash_ce_n_o <= 1'b1;
                        flash_oe_n_o <= 1'b1;
                        cnt          <= fsq_pkg::RD_ACCESS_CNT;
                        if (dq_sync[fsq_pkg::SR_READY_BIT]) begin
                            cnt   <= fsq_pkg::WR_PULSE_CNT;
                            state <= S_WR1;
                        end
                    end
                end
                S_WR1: begin
                    flash_addr_o  <= addr;
                    flash_dq_o    <= rd_phase ? fsq_pkg::CMD_READ_STATUS
                                   : phase ? second_cmd : first_cmd;
                    flash_dq_oe_o <= 1'b1;
                    flash_ce_n_o  <= 1'b0;
                    flash_we_n_o  <= 1'b0;
                    if (cnt != 4'h0) begin
                        cnt <= cnt - 4'h1;
                    end else begin
                        flash_we_n_o <= 1'b1;
                        state        <= S_WR2;
                    end
                end
                S_WR2: begin
                    flash_ce_n_o  <= 1'b1;
                    flash_dq_oe_o <= 1'b0;
                    cnt           <= fsq_pkg::WR_PULSE_CNT;
                    if (rd_phase) begin
                        rd_phase <= 1'b0;
                        cnt      <= fsq_pkg::RD_ACCESS_CNT;
                        state    <= S_POLL;
                    end else if (op == fsq_pkg::FSQ_OP_LOCK_READ
                              && !phase) begin
                        cnt   <= fsq_pkg::RD_ACCESS_CNT;
                        addr  <= addr + fsq_pkg::LOCK_INFO_OFS;
                        state <= S_RDINF;
                    end else if (two_cycle && !phase) begin
                        phase <= 1'b1;
                        state <= S_WR1;
                    end else if (op == fsq_pkg::FSQ_OP_CLR_STAT
                              || op == fsq_pkg::FSQ_OP_READ_ARR
                              || op == fsq_pkg::FSQ_OP_LOCK_READ) begin
                        state <= S_DONE;
                    end else begin
                        cnt   <= fsq_pkg::RD_ACCESS_CNT;
                        state <= S_WAIT;
                    end
                end
                // Reads now return status wait for ready
                S_WAIT: begin
                    cnt <= fsq_pkg::RD_ACCESS_CNT;
                    state <= S_RDST;
                end
                S_RDST: begin
                    flash_ce_n_o <= 1'b0;
                    flash_oe_n_o <= 1'b0;
                    if (cnt != 4'h0) begin
                        cnt <= cnt - 4'h1;
                    end else begin
                        flash_ce_n_o <= 1'b1;
                        flash_oe_n_o <= 1'b1;
                        cnt          <= fsq_pkg::RD_ACCESS_CNT;
                        if (dq_sync[fsq_pkg::SR_READY_BIT]) begin
                            rdata_o <= dq_sync;
                            err_o   <= dq_sync[fsq_pkg::SR_PROG_ERR]
                                     | dq_sync[fsq_pkg::SR_ERASE_ERR];
                            state   <= S_DONE;
                        end
                    end
                end
                S_RDINF: begin
                    flash_addr_o <= addr;
                    flash_ce_n_o <= 1'b0;
                    flash_oe_n_o <= 1'b0;
                    if (cnt != 4'h0) begin
                        cnt <= cnt - 4'h1;
                    end else begin
                        flash_ce_n_o <= 1'b1;
                        flash_oe_n_o <= 1'b1;
                        rdata_o  <= dq_sync;
                        locked_o <= dq_sync[fsq_pkg::LOCK_BIT];
                        phase    <= 1'b1;
                        cnt      <= fsq_pkg::WR_PULSE_CNT;
                        state    <= S_WR1;
                    end
                end
                S_DONE: begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                    state  <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// File: bench/fsq_ctrl_monitor.sv
/* Assertions on the flash controller's command bus and handshake.
   Bound into fsq_ctrl; sees its ports only. */
`timescale 1ns/10ps
module fsq_ctrl_monitor (
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    input wire logic        req_i,
    input wire logic        busy_o,
    input wire logic        done_o,
    input wire logic        err_o,
    input wire logic        pin_event_o,
    input wire logic [23:0] flash_addr_o,
    input wire logic [15:0] flash_dq_o,
    input wire logic        flash_dq_oe_o,
    input wire logic        flash_ce_n_o,
    input wire logic        flash_we_n_o,
    input wire logic        flash_oe_n_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    a_req_taken: assert property (
        req_i && !busy_o && !done_o |=> busy_o) else $error("req lost");
    // Status reads are selected before the ready bit is polled
    a_poll_first: assert property (
        $rose(busy_o)
        |=> !flash_we_n_o && flash_dq_o == fsq_pkg::CMD_READ_STATUS)
        else $error("status not selected");
    a_write_width: assert property (
        $fell(flash_we_n_o) |-> !flash_we_n_o [*2] ##1 flash_we_n_o)
        else $error("write width");
    a_write_drive: assert property (
        !flash_we_n_o |-> flash_dq_oe_o && !flash_ce_n_o && flash_oe_n_o)
        else $error("write strobes");
    a_write_stable: assert property (
        !flash_we_n_o && !$past(flash_we_n_o)
        |-> $stable(flash_addr_o) && $stable(flash_dq_o))
        else $error("write unstable");
    a_release_gap: assert property (
        $rose(flash_we_n_o) |=> flash_ce_n_o) else $error("no release");
    a_err_in_op: assert property (
        $changed(err_o) |-> busy_o || done_o) else $error("err moved");
    a_idle_quiet: assert property (
        !busy_o && !done_o |-> flash_ce_n_o && !flash_dq_oe_o)
        else $error("idle bus");
    c_done_ok: cover property (done_o && !err_o);
    c_err: cover property ($rose(err_o));
    c_pin_event: cover property (pin_event_o);
endmodule

bind fsq_ctrl fsq_ctrl_monitor i_mon (.mclk_i, .rst_n_i, .req_i, .busy_o,
    .done_o, .err_o, .pin_event_o, .flash_addr_o, .flash_dq_o,
    .flash_dq_oe_o, .flash_ce_n_o, .flash_we_n_o, .flash_oe_n_o);

// File: bench/fsq_flash_model.sv
/* Behavioural flash device: commands, status, lock bits, status pin.
   Assumes the host holds strobes steady through each write. */
`timescale 1ns/10ps
module fsq_flash_model (
    input  wire logic        rst_n_i,
    input  wire logic        program_enable_voltage_low_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [15:0] dq_i,
    input  wire logic        dq_oe_i,
    input  wire logic        ce_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    output logic      [15:0] dq_o,
    output logic             status_pin_o
);
    // No reset except mode and pulse_mode: lock_q models non-volatile cells
    logic [63:0] lock_q = '0;
    logic [6:0]  sr = '0;
    logic [1:0]  mode = '0;
    logic [7:0]  setup = '0;
    logic [7:0]  d;
    logic [5:0]  blk;
    logic        pulse_mode = 1'h0;
    logic        busy = 1'h0;
    logic [15:0] rd;
    logic [15:0] last = '0;

    always @(negedge rst_n_i) begin
        pulse_mode = 1'h0;
        mode = '0;
    end

    always @(posedge we_n_i) begin
        if (!ce_n_i && dq_oe_i && rst_n_i) begin
            d = dq_i[7:0];
            blk = addr_i[21:16];
            if (setup == 8'hB8) begin
                pulse_mode = d[1:0] != 2'h0;
                setup = '0;
            end else if (setup == 8'h60) begin
                setup = '0;
                // Writes during the busy time are lost
                busy = 1'h1;
                #1000;
                if (program_enable_voltage_low_i)
                    sr[5:4] = sr[5:4] | (d[0] ? 2'h1 : 2'h2);
                else if (d == 8'h01)
                    lock_q[blk] = 1'h1;
                else if (d == 8'hD0)
                    lock_q = '0;
                busy = 1'h0;
            end else begin
                setup = (d == 8'hB8 || d == 8'h60) ? d : 8'h00;
                if (d == 8'h60 || d == 8'h70)
                    mode = 2'h1;
                if (d == 8'h90)
                    mode = 2'h2;
                if (d == 8'hFF)
                    mode = 2'h0;
                if (d == 8'h50)
                    sr = '0;
            end
        end
    end

    always_comb begin
        case (mode)
            2'h0:    rd = 16'hFFFF;
            2'h1:    rd = {8'h00, !busy, sr};
            default: rd = {15'h0000, addr_i[15:0] == 16'h0002
                           && lock_q[addr_i[21:16]]};
        endcase
    end

    // Released bus shows the inverse of the last value
    always @(ce_n_i, oe_n_i, rd) begin
        if (!ce_n_i && !oe_n_i) begin
            dq_o = rd;
            last = rd;
        end else
            dq_o = ~last;
    end
    assign status_pin_o = pulse_mode ? 1'h1 : !busy;
endmodule

// File: bench/testbench.sv
/* Bench for fsq_ctrl against a behavioural flash device.
   Assumes the design package and the flash model are compiled first. */
`timescale 1ns/10ps
module testbench;
    logic             mclk_i = 1'h0;
    logic             rst_n_i, req_i, program_enable_voltage_low;
    fsq_pkg::fsq_op_t op_i;
    logic [23:0]      addr_i, f_addr;
    logic [7:0]       cfg_i;
    logic             busy_o, done_o, err_o, locked_o, pin_event_o;
    logic [15:0]      rdata_o, f_dq_o, f_dq_i;
    logic             f_oe, f_ce_n, f_we_n, f_oe_n, f_sts;
    int               n_mismatch = 0;
    int               samples_checked = 0;
    int               n_ev = 0;

    always #25 mclk_i = ~mclk_i;
    always @(posedge mclk_i) if (pin_event_o === 1'h1) n_ev++;

    fsq_ctrl i_dut (.mclk_i, .rst_n_i, .req_i, .op_i, .addr_i, .cfg_i,
        .busy_o, .done_o, .err_o, .rdata_o, .locked_o, .pin_event_o,
        .flash_addr_o(f_addr), .flash_dq_o(f_dq_o), .flash_dq_oe_o(f_oe),
        .flash_dq_i(f_dq_i), .flash_ce_n_o(f_ce_n), .flash_we_n_o(f_we_n),
        .flash_oe_n_o(f_oe_n), .status_pin_i(f_sts));
    fsq_flash_model i_flash (.rst_n_i, .program_enable_voltage_low_i(program_enable_voltage_low),
        .addr_i(f_addr), .dq_i(f_dq_o), .dq_oe_i(f_oe), .ce_n_i(f_ce_n),
        .we_n_i(f_we_n), .oe_n_i(f_oe_n), .dq_o(f_dq_i),
        .status_pin_o(f_sts));

    task automatic stop_test();
        $display("Compares %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask

    task automatic run(input fsq_pkg::fsq_op_t op, input logic [23:0] a,
                       input logic [7:0] c);
        int n = 0;
        @(negedge mclk_i);
        op_i = op;
        addr_i = a;
        cfg_i = c;
        req_i = 1'h1;
        @(negedge mclk_i);
        req_i = 1'h0;
        while (done_o !== 1'h1 && n < 3000) begin
            @(negedge mclk_i);
            n++;
        end
        if (n == 3000) begin
            n_mismatch++;
            stop_test();
        end
    endtask

    initial begin
        rst_n_i = 1'h0;
        req_i = 1'h0;
        op_i = fsq_pkg::FSQ_OP_READ_ARR;
        addr_i = '0;
        cfg_i = '0;
        program_enable_voltage_low = 1'h0;
        repeat (8) @(negedge mclk_i);
        rst_n_i = 1'h1;
        run(fsq_pkg::FSQ_OP_PIN_CFG, 24'h0, 8'h00);
        n_ev = 0;
        run(fsq_pkg::FSQ_OP_LOCK_SET, 24'h010000, 8'h00);
        chk("status", 16'h0080, rdata_o);
        chk("busy edges", 16'h0001, 16'(n_ev));
        run(fsq_pkg::FSQ_OP_LOCK_READ, 24'h010000, 8'h00);
        chk("lock b1", 16'h0001, 16'(locked_o));
        run(fsq_pkg::FSQ_OP_LOCK_READ, 24'h020000, 8'h00);
        chk("lock b2", 16'h0000, 16'(locked_o));
        $display("Test lock_set done");
        run(fsq_pkg::FSQ_OP_PIN_CFG, 24'h0, 8'hFF);
        n_ev = 0;
        run(fsq_pkg::FSQ_OP_LOCK_CLR, 24'h3F0000, 8'h00);
        chk("pulses", 16'h0000, 16'(n_ev));
        run(fsq_pkg::FSQ_OP_LOCK_READ, 24'h010000, 8'h00);
        chk("lock b1", 16'h0000, 16'(locked_o));
        $display("Test clear_all done");
        program_enable_voltage_low = 1'h1;
        run(fsq_pkg::FSQ_OP_LOCK_SET, 24'h030000, 8'h00);
        chk("err", 16'h0001, 16'(err_o));
        chk("status", 16'h0090, rdata_o);
        run(fsq_pkg::FSQ_OP_LOCK_READ, 24'h030000, 8'h00);
        chk("lock b3", 16'h0000, 16'(locked_o));
        run(fsq_pkg::FSQ_OP_CLR_STAT, 24'h0, 8'h00);
        run(fsq_pkg::FSQ_OP_LOCK_CLR, 24'h0, 8'h00);
        chk("status", 16'h00A0, rdata_o);
        program_enable_voltage_low = 1'h0;
        run(fsq_pkg::FSQ_OP_CLR_STAT, 24'h0, 8'h00);
        run(fsq_pkg::FSQ_OP_PIN_CFG, 24'h0, 8'h00);
        chk("err", 16'h0000, 16'(err_o));
        $display("Test lock_fail done");
        run(fsq_pkg::FSQ_OP_PIN_CFG, 24'h0, 8'h02);
        run(fsq_pkg::FSQ_OP_LOCK_SET, 24'h050000, 8'h00);
        @(negedge mclk_i);
        rst_n_i = 1'h0;
        repeat (8) @(negedge mclk_i);
        rst_n_i = 1'h1;
        n_ev = 0;
        run(fsq_pkg::FSQ_OP_LOCK_READ, 24'h050000, 8'h00);
        chk("lock b5", 16'h0001, 16'(locked_o));
        run(fsq_pkg::FSQ_OP_LOCK_CLR, 24'h0, 8'h00);
        chk("busy edges", 16'h0001, 16'(n_ev));
        run(fsq_pkg::FSQ_OP_READ_ARR, 24'h0, 8'h00);
        $display("Test reset_keep done");
        stop_test();
    end
endmodule
